/* File: rtl/event_qualifier.sv */
// per selection register: how many qualified events occur this cycle
`timescale 1ns/10ps
`default_nettype none
module event_qualifier
    import perf_event_pkg::*;
#(
    parameter bit RETIRE_GROUP = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [DATA_W-1:0] select_reg,
    input wire uop_slot_type [SLOTS-1:0] uop_slots,
    input wire flush_info_type flush,
    output logic [INC_W-1:0] inc
);

    logic [CODE_W-1:0] code;
    logic [MASK_W-1:0] mask;
    logic [SLOTS-1:0] hit;

    assign code = select_reg[CODE_HI:CODE_LO];
    assign mask = select_reg[MASK_LO +: MASK_W];

    // ****************************************
    // per-slot qualification
    // ****************************************
    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            uop_slot_type u;
            logic port_ok;
            assign u = uop_slots[s];
            assign port_ok = (u.port == PORT_0) || (u.port == PORT_2);
            always_comb begin
                hit[s] = 1'b0;
                if (!RETIRE_GROUP && u.valid) begin
                    case (code)
                        CODE_NARROW_SIMD: hit[s] = (u.kind == KIND_NARROW_SIMD)
                            && mask[MASK_ALL_BIT];
                        CODE_WIDE_SIMD: hit[s] = (u.kind == KIND_WIDE_SIMD)
                            && mask[MASK_ALL_BIT];
                        CODE_STACK_FP: hit[s] = (u.kind == KIND_STACK_FP)
                            && (u.op_class == OP_COMPUTE) && mask[MASK_ALL_BIT];
                        // assists are not filtered out; integer moves never match kind
                        CODE_FP_SIMD_MOVE: hit[s] = (u.kind == KIND_FP_SIMD_MOVE) && port_ok
                            && ((((u.op_class == OP_STORE) || (u.op_class == OP_MOVE))
                            && mask[MASK_ALL_STORE_MOVE_BIT])
                            || ((u.op_class == OP_LOAD) && mask[MASK_LOAD_BIT]));
                        default: hit[s] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************
    // sum of events
    // ****************************************
    always_comb begin
        inc = '0;
        if (!RETIRE_GROUP) begin
            for (int i = 0; i < SLOTS; i++) begin
                inc = inc + INC_W'(hit[i]);
            end
        end else if (code == CODE_PIPE_CLEAR) begin
            inc = INC_W'(flush.active && mask[MASK_CLEAR_BIT])
                + INC_W'(flush.mem_order && mask[MASK_MEM_ORDER_FLUSH_BIT])
                + INC_W'(flush.self_mod && mask[MASK_SELF_MOD_CODE_FLUSH_BIT]);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_NO_MASK_NO_COUNT: assert property (
        (mask == '0) |-> (inc == '0))
        else $error("count with empty mask");
    AST_WIDE_EACH_UOP: assert property (
        (!RETIRE_GROUP && code == CODE_WIDE_SIMD && mask[MASK_ALL_BIT]
        && uop_slots[0].valid && uop_slots[0].kind == KIND_WIDE_SIMD
        && uop_slots[1].valid && uop_slots[1].kind == KIND_WIDE_SIMD
        && uop_slots[2].valid && uop_slots[2].kind == KIND_WIDE_SIMD) |-> (inc == 3'd3))
        else $error("wide uops not counted one by one");
    AST_STACK_FP_SKIPS_MOVES: assert property (
        (code == CODE_STACK_FP && uop_slots[0].op_class != OP_COMPUTE
        && uop_slots[1].op_class != OP_COMPUTE && uop_slots[2].op_class != OP_COMPUTE)
        |-> (inc == '0))
        else $error("stack fp data movement counted");
    AST_MOVE_PORT_ONLY: assert property (
        (!RETIRE_GROUP && code == CODE_FP_SIMD_MOVE
        && uop_slots[0].port[0] && uop_slots[1].port[0] && uop_slots[2].port[0])
        |-> (inc == '0))
        else $error("move counted off ports 0 and 2");
    AST_INT_MOVE_IGNORED: assert property (
        (!RETIRE_GROUP && code == CODE_FP_SIMD_MOVE
        && uop_slots[0].kind != KIND_FP_SIMD_MOVE && uop_slots[1].kind != KIND_FP_SIMD_MOVE
        && uop_slots[2].kind != KIND_FP_SIMD_MOVE) |-> (inc == '0))
        else $error("non fp move counted");
    AST_RETIRE_ONLY_CLEAR: assert property (
        (RETIRE_GROUP && code != CODE_PIPE_CLEAR) |-> (inc == '0))
        else $error("retire group counted a foreign event");
    AST_MO_CLEAR_ONCE: assert property (
        (RETIRE_GROUP && code == CODE_PIPE_CLEAR
        && mask == (16'h0001 << MASK_MEM_ORDER_FLUSH_BIT))
        |-> (inc == INC_W'(flush.mem_order)))
        else $error("memory order clear miscounted");

endmodule
`default_nettype wire

/* File: rtl/perf_counter_slot.sv */
// one event counter with level or edge counting and wrap detection
`timescale 1ns/10ps
`default_nettype none
module perf_counter_slot
    import perf_event_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [INC_W-1:0] inc,
    input wire logic enable,
    input wire logic edge_mode,
    input wire logic wr_en,
    input wire logic [CNT_W-1:0] wr_data,
    output logic [CNT_W-1:0] count_q,
    output logic wrap_q
);

    logic inc_nz_q;
    logic [INC_W-1:0] step;
    logic [CNT_W:0] sum;

    // edge mode turns a duration into one count per burst
    assign step = edge_mode ? INC_W'((inc != '0) && !inc_nz_q) : inc;
    assign sum = {1'b0, count_q} + {{(CNT_W+1-INC_W){1'b0}}, step};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inc_nz_q <= 1'b0;
        end else begin
            inc_nz_q <= enable && (inc != '0);
        end
    end

    // software write wins over a same-cycle increment
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (wr_en) begin
            count_q <= wr_data;
        end else if (enable) begin
            count_q <= sum[CNT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrap_q <= 1'b0;
        end else begin
            wrap_q <= enable && !wr_en && sum[CNT_W];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_LEVEL_COUNT_ADDS: assert property (
        (enable && !edge_mode && !wr_en) |=>
        (count_q == CNT_W'($past(count_q) + CNT_W'($past(inc)))))
        else $error("level count did not add increment");
    AST_EDGE_ONE_PER_BURST: assert property (
        (enable && edge_mode && !wr_en && inc != '0) ##1
        (enable && edge_mode && !wr_en && inc != '0) |=> $stable(count_q))
        else $error("edge mode counted a held condition twice");

endmodule
`default_nettype wire

/* File: rtl/perf_event_pkg.sv */
// constants, types and helpers shared by the event qualification design
package perf_event_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int SLOTS = 3;
    localparam int INC_W = 3;
    localparam int NUM_SEL = 4;
    localparam int NUM_CNT = 10;
    localparam int CNT_W = 32;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ****************************************
    // selection register fields
    // ****************************************
    localparam int CODE_HI = 31;
    localparam int CODE_LO = 25;
    localparam int CODE_W = 7;
    localparam int MASK_LO = 9;
    localparam int MASK_W = 16;
    localparam logic [DATA_W-1:0] SEL_WRITE_MASK = 32'hffff_fe00;
    localparam logic [DATA_W-1:0] SEL_RESET = 32'h0000_0000;

    localparam logic [CODE_W-1:0] CODE_NARROW_SIMD = 7'h02;
    localparam logic [CODE_W-1:0] CODE_WIDE_SIMD = 7'h1a;
    localparam logic [CODE_W-1:0] CODE_STACK_FP = 7'h04;
    localparam logic [CODE_W-1:0] CODE_FP_SIMD_MOVE = 7'h2e;
    localparam logic [CODE_W-1:0] CODE_PIPE_CLEAR = 7'h02;

    localparam int MASK_ALL_BIT = 15;
    localparam int MASK_ALL_STORE_MOVE_BIT = 3;
    localparam int MASK_LOAD_BIT = 4;
    localparam int MASK_CLEAR_BIT = 0;
    localparam int MASK_MEM_ORDER_FLUSH_BIT = 2;
    localparam int MASK_SELF_MOD_CODE_FLUSH_BIT = 3;

    // ****************************************
    // counter configuration register fields
    // ****************************************
    localparam int CFG_ENABLE_BIT = 12;
    localparam int CFG_SEL_LO = 13;
    localparam int CFG_SEL_HI = 15;
    localparam int CFG_EDGE_BIT = 24;
    localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 32'h0100_f000;
    localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] FP_GROUP_SELECT = 3'h1;
    localparam logic [2:0] RETIRE_GROUP_SELECT = 3'h5;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] SEL_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] CFG_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] CNT_BASE = 12'h080;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h0c0;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h0c4;
    localparam logic [ADDR_W-1:0] REGION_MASK = 12'hfc0;
    localparam logic [ADDR_W-1:0] WORD_MASK = 12'h003;

    // ****************************************
    // event source types
    // ****************************************
    typedef enum logic [2:0] {
        KIND_OTHER = 3'h0,
        KIND_NARROW_SIMD = 3'h1,
        KIND_WIDE_SIMD = 3'h2,
        KIND_STACK_FP = 3'h3,
        KIND_FP_SIMD_MOVE = 3'h4,
        KIND_INT_MOVE = 3'h5
    } uop_kind_type;

    typedef enum logic [1:0] {
        OP_COMPUTE = 2'h0,
        OP_LOAD = 2'h1,
        OP_STORE = 2'h2,
        OP_MOVE = 2'h3
    } op_class_type;

    localparam logic [1:0] PORT_0 = 2'h0;
    localparam logic [1:0] PORT_2 = 2'h2;

    typedef struct packed {
        logic valid;
        uop_kind_type kind;
        op_class_type op_class;
        logic [1:0] port;
        logic assist;
    } uop_slot_type;

    typedef struct packed {
        logic active;
        logic mem_order;
        logic self_mod;
    } flush_info_type;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

    // counters 8..17 live at index 0..9
    function automatic logic [1:0] counter_source(input int idx);
        case (idx)
            0, 1: counter_source = 2'd0;
            2, 3: counter_source = 2'd1;
            4, 5, 8: counter_source = 2'd2;
            default: counter_source = 2'd3;
        endcase
    endfunction

endpackage

/* File: rtl/perf_event_select_decode.sv */
// event qualification top: selection registers, counters, apb slave, interrupt
`timescale 1ns/10ps
`default_nettype none
module perf_event_select_decode
    import perf_event_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire uop_slot_type [SLOTS-1:0] uop_slots,
    input wire flush_info_type flush,
    output logic irq_q
);

    // ****************************************
    // storage
    // ****************************************
    logic [DATA_W-1:0] sel_q [NUM_SEL];
    logic [DATA_W-1:0] cfg_q [NUM_CNT];
    logic [NUM_CNT-1:0] status_q;
    logic [NUM_CNT-1:0] status_d;
    logic [NUM_CNT-1:0] mask_q;
    logic [CNT_W-1:0] cnt_q [NUM_CNT];
    logic [NUM_CNT-1:0] wrap;
    logic [NUM_CNT-1:0] cnt_en;
    logic [NUM_CNT-1:0] cnt_wr;
    logic [INC_W-1:0] sel_inc [NUM_SEL];

    apb_req_type req;
    logic wr_take;
    logic [ADDR_W-1:0] offset;
    logic [3:0] word_idx;
    logic in_sel;
    logic in_cfg;
    logic in_cnt;
    logic is_status;
    logic is_mask;
    logic addr_ok;
    logic [DATA_W-1:0] rd_d;

    assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite,
                   pwdata: pwdata};

    // ****************************************
    // address decode
    // ****************************************
    assign word_idx = req.paddr[5:2];
    always_comb begin
        offset = req.paddr & ~REGION_MASK;
        in_sel = ((req.paddr & REGION_MASK) == SEL_BASE) && (offset < ADDR_W'(4 * NUM_SEL));
        in_cfg = ((req.paddr & REGION_MASK) == CFG_BASE) && (offset < ADDR_W'(4 * NUM_CNT));
        in_cnt = ((req.paddr & REGION_MASK) == CNT_BASE) && (offset < ADDR_W'(4 * NUM_CNT));
        is_status = (req.paddr == STATUS_ADDR);
        is_mask = (req.paddr == MASK_ADDR);
        addr_ok = ((req.paddr & WORD_MASK) == '0)
            && (in_sel || in_cfg || in_cnt || is_status || is_mask);
    end

    // ****************************************
    // apb slave
    // ****************************************
    // answer is prepared in the setup cycle, so access phases never wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= req.psel && !req.penable;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= req.psel && !req.penable && !addr_ok;
        end
    end

    always_comb begin
        rd_d = '0;
        if (in_sel) begin
            rd_d = sel_q[word_idx[1:0]];
        end else if (in_cfg) begin
            rd_d = cfg_q[word_idx];
        end else if (in_cnt) begin
            rd_d = cnt_q[word_idx];
        end else if (is_status) begin
            rd_d = DATA_W'(status_q);
        end else if (is_mask) begin
            rd_d = DATA_W'(mask_q);
        end
    end

    // read data sampled at setup; a counter read shows its value from that cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= '0;
        end else if (req.psel && !req.penable) begin
            prdata_q <= (addr_ok && !req.pwrite) ? rd_d : '0;
        end
    end

    assign wr_take = req.psel && req.penable && pready_q && req.pwrite && !pslverr_q;

    // ****************************************
    // selection and configuration registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                sel_q[i] <= SEL_RESET;
            end
        end else if (wr_take && in_sel) begin
            sel_q[word_idx[1:0]] <= req.pwdata & SEL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
        end else if (wr_take && in_cfg) begin
            cfg_q[word_idx] <= req.pwdata & CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= '0;
        end else if (wr_take && is_mask) begin
            mask_q <= req.pwdata[NUM_CNT-1:0];
        end
    end

    // ****************************************
    // qualifiers: 0,1 fp group, 2,3 retire group
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM_SEL; g++) begin : g_sel
            event_qualifier #(
                .RETIRE_GROUP(g >= 2)
            ) u_qual (
                .clk(clk),
                .reset_n(reset_n),
                .select_reg(sel_q[g]),
                .uop_slots(uop_slots),
                .flush(flush),
                .inc(sel_inc[g])
            );
        end
    endgenerate

    // ****************************************
    // counters 8..17
    // ****************************************
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_cnt
            localparam logic [1:0] SRC = counter_source(g);
            localparam logic [2:0] WANT_SELECT =
                (SRC >= 2'd2) ? RETIRE_GROUP_SELECT : FP_GROUP_SELECT;
            // a mismatched select field leaves the counter frozen
            assign cnt_en[g] = cfg_q[g][CFG_ENABLE_BIT]
                && (cfg_q[g][CFG_SEL_HI:CFG_SEL_LO] == WANT_SELECT);
            assign cnt_wr[g] = wr_take && in_cnt && (word_idx == 4'(g));
            perf_counter_slot u_slot (
                .clk(clk),
                .reset_n(reset_n),
                .inc(sel_inc[SRC]),
                .enable(cnt_en[g]),
                .edge_mode(cfg_q[g][CFG_EDGE_BIT]),
                .wr_en(cnt_wr[g]),
                .wr_data(req.pwdata),
                .count_q(cnt_q[g]),
                .wrap_q(wrap[g])
            );
        end
    endgenerate

    // ****************************************
    // interrupt status
    // ****************************************
    // a wrap in the clearing cycle survives the write-one-to-clear
    always_comb begin
        status_d = status_q;
        if (wr_take && is_status) begin
            status_d = status_d & ~req.pwdata[NUM_CNT-1:0];
        end
        status_d = status_d | wrap;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // one cycle behind status; keeps the pin straight from a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_STATUS_SET_WINS:
    assert property (
        (wrap[0] && wr_take && is_status && req.pwdata[0]) |=> status_q[0])
        else $error("wrap lost against status clear");
    AST_IRQ_FOLLOWS_MASK:
    assert property (
        ##1 (irq_q == |($past(status_q) & $past(mask_q))))
        else $error("interrupt level wrong");
    AST_SELECT_GATES_COUNT:
    assert property (
        (cfg_q[1][CFG_SEL_HI:CFG_SEL_LO] != FP_GROUP_SELECT && !cnt_wr[1])
        |=> $stable(cnt_q[1]))
        else $error("counter moved with wrong select");
    AST_RETIRE_COUNTER_SOURCE:
    assert property (
        (cnt_en[8] && !cfg_q[8][CFG_EDGE_BIT] && !cnt_wr[8])
        |=> (cnt_q[8] == CNT_W'($past(cnt_q[8]) + CNT_W'($past(sel_inc[2])))))
        else $error("counter 16 not fed by register two");
    AST_SMC_CLEAR_ONCE:
    assert property (
        (sel_q[3][CODE_HI:CODE_LO] == CODE_PIPE_CLEAR
        && sel_q[3][MASK_LO +: MASK_W] == (16'h0001 << MASK_SELF_MOD_CODE_FLUSH_BIT))
        |-> (sel_inc[3] == INC_W'(flush.self_mod)))
        else $error("self modifying clear miscounted");
    AST_APB_ZERO_WAIT:
    assert property (
        (req.psel && !req.penable) |=> pready_q)
        else $error("apb answer late");

endmodule
`default_nettype wire

/* File: tb/event_source_model.sv */
// behavioural model of the pipeline event sources
`timescale 1ns/10ps
`default_nettype none
module event_source_model
    import perf_event_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire uop_slot_type [SLOTS-1:0] slot_req,
    input wire flush_info_type flush_req,
    output var uop_slot_type [SLOTS-1:0] uop_slots,
    output var flush_info_type flush
);
    logic [7:0] junk_q;
    // idle slots carry changing junk: only valid may gate counting
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            junk_q <= 8'h5a;
            uop_slots <= '0;
            flush <= '0;
        end else begin
            junk_q <= junk_q + 8'h3b;
            for (int i = 0; i < SLOTS; i++) begin
                uop_slots[i] <= slot_req[i].valid ? slot_req[i] : uop_slot_type'({1'b0, junk_q});
            end
            flush <= flush_req;
        end
    end
endmodule
`default_nettype wire

/* File: tb/perf_event_select_decode_tb.sv */
// self-checking bench for the event qualification block
`timescale 1ns/10ps
`default_nettype none
module perf_event_select_decode_tb
    import perf_event_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    uop_slot_type [SLOTS-1:0] slot_req = '0;
    uop_slot_type [SLOTS-1:0] uop_slots;
    flush_info_type flush_req = '0;
    flush_info_type flush;
    logic [DATA_W-1:0] rd;
    logic er;
    int n_fail = 0;
    int total_checks = 0;
    perf_event_select_decode DUT (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .uop_slots(uop_slots), .flush(flush),
        .irq_q(irq_q));
    event_source_model src (.clk(clk), .reset_n(reset_n), .slot_req(slot_req),
        .flush_req(flush_req), .uop_slots(uop_slots), .flush(flush));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // pready is taken at the rising edge; the request stands until then
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic uop_slot_type sl(input uop_kind_type k, input op_class_type o,
        input logic [1:0] p, input logic a);
        sl = '{1'b1, k, o, p, a};
    endfunction
    task automatic fp_case(input logic [6:0] code, input int b,
        input uop_slot_type [SLOTS-1:0] s, input logic [31:0] exp);
        apb(SEL_BASE, 1'b1, {code, 25'h0} | (32'h1 << (MASK_LO + b)));
        apb(CNT_BASE, 1'b1, '0);
        slot_req <= s;
        repeat (4) @(posedge clk);
        slot_req <= '0;
        repeat (3) @(posedge clk);
        apb(CNT_BASE, 1'b0, '0);
        chk("fp counter", rd, exp);
    endtask
    task automatic ret_case(input int b, input logic edge_on, input flush_info_type p,
        input logic [31:0] exp);
        apb(CFG_BASE + 12'h010, 1'b1, 32'h0000_b000 | {7'h0, edge_on, 24'h0});
        apb(SEL_BASE + 12'h008, 1'b1, {CODE_PIPE_CLEAR, 25'h0} | (32'h1 << (MASK_LO + b)));
        apb(CNT_BASE + 12'h010, 1'b1, '0);
        // two clears of three cycles each, apart by one idle cycle
        repeat (2) begin
            flush_req <= p;
            @(posedge clk);
            flush_req <= '{1'b1, 1'b0, 1'b0};
            repeat (2) @(posedge clk);
            flush_req <= '0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        apb(CNT_BASE + 12'h010, 1'b0, '0);
        chk("retire counter", rd, exp);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_apb();
        apb(SEL_BASE, 1'b0, '0);
        chk("select reset", rd, SEL_RESET);
        apb(12'h0c8, 1'b0, '0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        apb(12'h042, 1'b0, '0);
        chk("misaligned error", {31'h0, er}, 32'h1);
    endtask
    task automatic test_fp_group();
        apb(CFG_BASE, 1'b1, 32'h0000_3000);
        apb(CFG_BASE + 12'h008, 1'b1, 32'h0000_3000);
        apb(CFG_BASE + 12'h004, 1'b1, 32'h0000_5000);
        fp_case(CODE_NARROW_SIMD, MASK_ALL_BIT, {3{sl(KIND_NARROW_SIMD, OP_COMPUTE, PORT_0, 1'b0)}},
            32'd12);
        fp_case(CODE_WIDE_SIMD, MASK_ALL_BIT, {3{sl(KIND_WIDE_SIMD, OP_LOAD, PORT_2, 1'b0)}},
            32'd12);
        fp_case(CODE_STACK_FP, MASK_ALL_BIT, {sl(KIND_STACK_FP, OP_COMPUTE, PORT_0, 1'b0),
            sl(KIND_STACK_FP, OP_LOAD, PORT_0, 1'b0), sl(KIND_STACK_FP, OP_MOVE, PORT_0, 1'b0)},
            32'd4);
        fp_case(CODE_FP_SIMD_MOVE, MASK_ALL_STORE_MOVE_BIT, {sl(KIND_FP_SIMD_MOVE, OP_STORE, PORT_0,
            1'b0), sl(KIND_FP_SIMD_MOVE, OP_MOVE, PORT_2, 1'b0), sl(KIND_FP_SIMD_MOVE, OP_STORE,
            2'h1, 1'b0)}, 32'd8);
        fp_case(CODE_FP_SIMD_MOVE, MASK_LOAD_BIT, {sl(KIND_FP_SIMD_MOVE, OP_LOAD, PORT_2, 1'b1),
            sl(KIND_INT_MOVE, OP_LOAD, PORT_0, 1'b0), sl(KIND_FP_SIMD_MOVE, OP_LOAD, PORT_0, 1'b0)},
            32'd8);
        fp_case(CODE_WIDE_SIMD, MASK_ALL_BIT, {3{sl(KIND_NARROW_SIMD, OP_COMPUTE, PORT_0, 1'b0)}},
            32'd0);
        apb(CNT_BASE + 12'h008, 1'b0, '0);
        chk("idle group counter", rd, 32'h0);
        apb(CNT_BASE + 12'h004, 1'b0, '0);
        chk("wrong select counter", rd, 32'h0);
    endtask
    task automatic test_retire();
        ret_case(MASK_CLEAR_BIT, 1'b0, '{1'b1, 1'b0, 1'b0}, 32'd6);
        ret_case(MASK_CLEAR_BIT, 1'b1, '{1'b1, 1'b0, 1'b0}, 32'd2);
        ret_case(MASK_MEM_ORDER_FLUSH_BIT, 1'b0, '{1'b1, 1'b1, 1'b0}, 32'd2);
        ret_case(MASK_SELF_MOD_CODE_FLUSH_BIT, 1'b0, '{1'b1, 1'b0, 1'b1}, 32'd2);
        ret_case(MASK_MEM_ORDER_FLUSH_BIT, 1'b0, '{1'b1, 1'b0, 1'b1}, 32'd0);
    endtask
    task automatic test_irq();
        apb(SEL_BASE, 1'b1, {CODE_NARROW_SIMD, 25'h0} | 32'h0100_0000);
        apb(MASK_ADDR, 1'b1, 32'h1);
        apb(CNT_BASE, 1'b1, 32'hffff_ffff);
        slot_req[0] <= sl(KIND_NARROW_SIMD, OP_COMPUTE, PORT_0, 1'b0);
        @(posedge clk);
        slot_req <= '0;
        repeat (5) @(posedge clk);
        chk("irq raised", {31'h0, irq_q}, 32'h1);
        apb(STATUS_ADDR, 1'b0, '0);
        chk("status", rd, 32'h1);
        apb(MASK_ADDR, 1'b1, 32'h0);
        @(posedge clk);
        chk("irq masked", {31'h0, irq_q}, 32'h0);
        apb(MASK_ADDR, 1'b1, 32'h1);
        apb(STATUS_ADDR, 1'b1, 32'h1);
        apb(STATUS_ADDR, 1'b0, '0);
        chk("status cleared", rd, 32'h0);
        chk("irq cleared", {31'h0, irq_q}, 32'h0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        test_apb();
        test_fp_group();
        test_retire();
        test_irq();
        give_verdict();
    end
    // the whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
